// ---- logic/twcs_control_status.sv ----
// The register offsets and the AXI4-Lite slave port were decided locally.
module twcs_control_status #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Event pulses, received address and master mode level from the bus engine
  input  wire logic              evBusError,
  input  wire logic              evArbLost,
  input  wire logic              evStartSent,
  input  wire logic              evAddrSent,
  input  wire logic              evDataSent,
  input  wire logic              evDataRecv,
  input  wire logic              evStopRecv,
  input  wire logic              rxAddrValid,
  input  wire logic [6:0]        rxAddr,
  input  wire logic              masterMode,
  // Engine and pin side
  output logic                   attnFlag,
  output logic                   ifaceEnable,
  output logic                   sclDriveLow,
  output logic                   sclTick,
  output logic                   irq
);
  localparam int EV_N = twcs_pkg::EV_N;

  // Bus state
  logic              awHeld, wHeld, next_awHeld, next_wHeld;
  logic [ADDR_W-1:0] awAddr, next_awAddr;
  logic [7:0]        wData, next_wData;
  logic              wLane, next_wLane;
  logic              next_awReady, next_wReady, next_bValid, next_arReady, next_rValid;
  logic [1:0]        next_bResp, next_rResp;
  logic [31:0]       next_rData;
  logic              wrFire;

  // Core state
  logic [7:0]        divisor, next_divisor;
  logic [1:0]        presc, next_presc;
  logic [4:0]        statusCode, next_statusCode;
  logic [4:0]        codeHold, next_codeHold;
  logic [7:0]        ownAddr, next_ownAddr;
  logic [EV_N-1:0]   irqSt, next_irqSt;
  logic [EV_N-1:0]   irqMask, next_irqMask;
  logic              next_attnFlag, next_ifaceEnable, next_sclDriveLow, next_sclTick, next_irq;
  twcs_pkg::twcs_phase_t phase, next_phase;
  logic [14:0]       cnt, next_cnt;
  logic [14:0]       halfCnt;
  logic [EV_N-1:0]   evVec;
  logic              addrMatch;
  logic              evAny;
  logic [4:0]        evCode;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    return b == twcs_pkg::OFF_DIVISOR || b == twcs_pkg::OFF_STATUS ||
           b == twcs_pkg::OFF_CONTROL || b == twcs_pkg::OFF_IRQ_ST ||
           b == twcs_pkg::OFF_IRQ_MSK || b == twcs_pkg::OFF_ADDR;
  endfunction : isMapped

  assign wrFire = awHeld && wHeld && !s_axi_bvalid;

  always_comb begin
    next_awHeld  = awHeld;
    next_wHeld   = wHeld;
    next_awAddr  = awAddr;
    next_wData   = wData;
    next_wLane   = wLane;
    next_bValid  = s_axi_bvalid;
    next_bResp   = s_axi_bresp;
    next_arReady = s_axi_arready;
    next_rValid  = s_axi_rvalid;
    next_rData   = s_axi_rdata;
    next_rResp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata[7:0];
      next_wLane = s_axi_wstrb[0];
    end
    if (wrFire) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bValid = 1'b1;
      next_bResp  = isMapped(awAddr) ? twcs_pkg::RESP_OKAY : twcs_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
    next_awReady = !next_awHeld && !next_bValid;
    next_wReady  = !next_wHeld && !next_bValid;
    if (s_axi_arvalid && s_axi_arready) begin
      next_arReady = 1'b0;
      next_rValid  = 1'b1;
      next_rResp   = isMapped(s_axi_araddr) ? twcs_pkg::RESP_OKAY : twcs_pkg::RESP_SLVERR;
      case (8'(s_axi_araddr))
        twcs_pkg::OFF_DIVISOR: next_rData = {24'h00_0000, divisor};
        twcs_pkg::OFF_STATUS:  next_rData = {24'h00_0000, statusCode, 1'b0, presc};
        twcs_pkg::OFF_CONTROL: next_rData = {24'h00_0000, attnFlag, 4'h0, ifaceEnable, 2'h0};
        twcs_pkg::OFF_IRQ_ST:  next_rData = {24'h00_0000, irqSt};
        twcs_pkg::OFF_IRQ_MSK: next_rData = {24'h00_0000, irqMask};
        twcs_pkg::OFF_ADDR:    next_rData = {24'h00_0000, ownAddr};
        default:               next_rData = 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rValid  = 1'b0;
      next_arReady = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= '0;
      wData         <= 8'h00;
      wLane         <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      awHeld        <= next_awHeld;
      wHeld         <= next_wHeld;
      awAddr        <= next_awAddr;
      wData         <= next_wData;
      wLane         <= next_wLane;
      s_axi_awready <= next_awReady;
      s_axi_wready  <= next_wReady;
      s_axi_bvalid  <= next_bValid;
      s_axi_bresp   <= next_bResp;
      s_axi_arready <= next_arReady;
      s_axi_rvalid  <= next_rValid;
      s_axi_rdata   <= next_rData;
      s_axi_rresp   <= next_rResp;
    end
  end

  // Own address or general call when recognition enabled
  assign addrMatch = rxAddrValid && (rxAddr == ownAddr[7:twcs_pkg::ADDR_LSB] ||
    (ownAddr[twcs_pkg::ADDR_GC_BIT] && rxAddr == twcs_pkg::GENERAL_CALL));
  assign evVec = {evStopRecv, evDataRecv, addrMatch, evDataSent,
                  evAddrSent, evStartSent, evArbLost, evBusError};
  assign evAny = ifaceEnable && (evVec != '0);

  always_comb begin
    evCode = twcs_pkg::CODE_IDLE;
    for (int k = EV_N - 1; k >= 0; k--) begin
      if (evVec[k]) begin
        evCode = twcs_pkg::EV_CODE[k];
      end
    end
  end

  // Prescale 4^ps is a shift by 2*ps
  assign halfCnt = twcs_pkg::HALF_BASE + (15'(divisor) << {presc, 1'b0});

  always_comb begin
    next_divisor     = divisor;
    next_presc       = presc;
    next_ownAddr     = ownAddr;
    next_irqMask     = irqMask;
    next_irqSt       = irqSt;
    next_attnFlag    = attnFlag;
    next_ifaceEnable = ifaceEnable;
    next_codeHold    = codeHold;
    next_phase       = phase;
    next_cnt         = cnt;
    next_sclTick     = 1'b0;
    if (wrFire && wLane) begin
      case (8'(awAddr))
        twcs_pkg::OFF_DIVISOR: next_divisor = wData;
        twcs_pkg::OFF_STATUS:  next_presc = wData[1:0];
        twcs_pkg::OFF_CONTROL: begin
          next_ifaceEnable = wData[twcs_pkg::CTL_EN_BIT];
          if (wData[twcs_pkg::CTL_FLAG_BIT]) begin
            next_attnFlag = 1'b0;
          end
        end
        twcs_pkg::OFF_IRQ_ST:  next_irqSt = irqSt & ~wData;
        twcs_pkg::OFF_IRQ_MSK: next_irqMask = wData;
        twcs_pkg::OFF_ADDR:    next_ownAddr = wData;
        default:               next_divisor = divisor;
      endcase
    end
    // Events win over a clear in the same cycle
    if (evAny) begin
      next_attnFlag = 1'b1;
      next_codeHold = evCode;
      next_irqSt    = next_irqSt | evVec;
    end
    if (!next_ifaceEnable) begin
      next_attnFlag = 1'b0;
    end
    next_statusCode = attnFlag ? codeHold : twcs_pkg::CODE_IDLE;
    if (masterMode && ifaceEnable && !attnFlag) begin
      if (cnt >= halfCnt - twcs_pkg::CNT_ONE) begin
        next_cnt     = 15'h0000;
        next_sclTick = 1'b1;
        next_phase   = (phase == twcs_pkg::PH_LOW) ? twcs_pkg::PH_HIGH : twcs_pkg::PH_LOW;
      end else begin
        next_cnt = cnt + twcs_pkg::CNT_ONE;
      end
    end else if (!masterMode || !ifaceEnable) begin
      next_cnt   = 15'h0000;
      next_phase = twcs_pkg::PH_HIGH;
    end
    next_sclDriveLow = next_attnFlag || (masterMode && next_phase == twcs_pkg::PH_LOW);
    next_irq = (next_irqSt & next_irqMask) != '0;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divisor     <= twcs_pkg::RST_DIVISOR;
      presc       <= twcs_pkg::RST_PRESC;
      ownAddr     <= twcs_pkg::RST_ADDR;
      irqMask     <= twcs_pkg::RST_MASK;
      irqSt       <= '0;
      attnFlag    <= 1'b0;
      ifaceEnable <= 1'b0;
      codeHold    <= twcs_pkg::CODE_IDLE;
      statusCode  <= twcs_pkg::CODE_IDLE;
      phase       <= twcs_pkg::PH_HIGH;
      cnt         <= 15'h0000;
      sclTick     <= 1'b0;
      sclDriveLow <= 1'b0;
      irq         <= 1'b0;
    end else begin
      divisor     <= next_divisor;
      presc       <= next_presc;
      ownAddr     <= next_ownAddr;
      irqMask     <= next_irqMask;
      irqSt       <= next_irqSt;
      attnFlag    <= next_attnFlag;
      ifaceEnable <= next_ifaceEnable;
      codeHold    <= next_codeHold;
      statusCode  <= next_statusCode;
      phase       <= next_phase;
      cnt         <= next_cnt;
      sclTick     <= next_sclTick;
      sclDriveLow <= next_sclDriveLow;
      irq         <= next_irq;
    end
  end

  a_event_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
    evAny && next_ifaceEnable |=> attnFlag) else $error("flag not set by event");
  a_code_after_rise: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(attnFlag) |=> statusCode == $past(codeHold)) else $error("status code late");
  a_idle_code: assert property (@(posedge sys_clk) disable iff (rst)
    !attnFlag |=> statusCode == twcs_pkg::CODE_IDLE) else $error("status not idle");
  a_scl_stretch: assert property (@(posedge sys_clk) disable iff (rst)
    attnFlag |-> sclDriveLow) else $error("clock released while flagged");
  a_bus_error_code: assert property (@(posedge sys_clk) disable iff (rst)
    ifaceEnable && evBusError |=> codeHold == twcs_pkg::EV_CODE[twcs_pkg::EV_BUS_ERROR])
    else $error("bad error code");
  a_start_code: assert property (@(posedge sys_clk) disable iff (rst)
    ifaceEnable && evStartSent && !evBusError && !evArbLost |=> attnFlag ##1
    statusCode == twcs_pkg::EV_CODE[twcs_pkg::EV_START_SENT] || !attnFlag)
    else $error("bad start code");
  a_arb_lost_flag: assert property (@(posedge sys_clk) disable iff (rst)
    ifaceEnable && evArbLost && !evBusError |=> codeHold == twcs_pkg::EV_CODE[twcs_pkg::EV_ARB_LOST])
    else $error("bad arb code");
  a_match_flag: assert property (@(posedge sys_clk) disable iff (rst)
    ifaceEnable && rxAddrValid && rxAddr == ownAddr[7:twcs_pkg::ADDR_LSB] |=> attnFlag || !ifaceEnable)
    else $error("match missed");
  a_clear_flag: assert property (@(posedge sys_clk) disable iff (rst)
    wrFire && wLane && 8'(awAddr) == twcs_pkg::OFF_CONTROL && wData[twcs_pkg::CTL_FLAG_BIT] && !evAny
    |=> !attnFlag) else $error("flag not cleared");
  a_tick_spacing: assert property (@(posedge sys_clk) disable iff (rst)
    sclTick |=> !sclTick [*7]) else $error("half period under eight cycles");
  a_no_slave_tick: assert property (@(posedge sys_clk) disable iff (rst)
    !masterMode |=> !sclTick) else $error("divider ran as slave");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
    irq == ((irqSt & irqMask) != '0)) else $error("irq mismatch");
endmodule : twcs_control_status

// ---- logic/twcs_pkg.sv ----
package twcs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_DIVISOR = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h10;
  localparam logic [7:0] OFF_ADDR    = 8'h14;

  // Reset values
  localparam logic [7:0] RST_DIVISOR = 8'h00;
  localparam logic [1:0] RST_PRESC   = 2'h0;
  localparam logic [7:0] RST_ADDR    = 8'hfe;
  localparam logic [7:0] RST_MASK    = 8'h00;

  // Field positions
  localparam int CTL_FLAG_BIT = 7;
  localparam int CTL_EN_BIT   = 2;
  localparam int ST_CODE_LSB  = 3;
  localparam int ADDR_GC_BIT  = 0;
  localparam int ADDR_LSB     = 1;

  // Events, lowest index has priority
  localparam int EV_N = 8;
  localparam int EV_BUS_ERROR  = 0;
  localparam int EV_ARB_LOST   = 1;
  localparam int EV_START_SENT = 2;
  localparam int EV_ADDR_SENT  = 3;
  localparam int EV_DATA_SENT  = 4;
  localparam int EV_ADDR_MATCH = 5;
  localparam int EV_DATA_RECV  = 6;
  localparam int EV_STOP_RECV  = 7;

  // Status codes per event index, and the no-information code
  localparam logic [4:0] CODE_IDLE = 5'h1f;
  localparam logic [EV_N-1:0][4:0] EV_CODE = {
    5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};

  localparam logic [6:0] GENERAL_CALL = 7'h00;

  // Bit rate: half period = HALF_BASE + divisor * 4^prescale
  localparam logic [14:0] HALF_BASE = 15'h0008;
  localparam logic [14:0] CNT_ONE   = 15'h0001;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    PH_HIGH = 1'b0,
    PH_LOW  = 1'b1
  } twcs_phase_t;
endpackage : twcs_pkg

// ---- verif/twcs_engine_model.sv ----
module twcs_engine_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Bench commands
  input  wire logic       evReq,
  input  wire logic [7:0] evSel,
  input  wire logic [6:0] seenAddr,
  // Design side
  input  wire logic       sclDriveLow,
  output logic [7:0]      evPulse,
  output logic            rxAddrValid,
  output logic [6:0]      rxAddr,
  output logic            sclLine
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-cycle event pulses; the address bus flips when not valid
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evPulse     <= 8'h00;
      rxAddrValid <= 1'h0;
      rxAddr      <= 7'h00;
    end else begin
      evPulse     <= evReq ? evSel : 8'h00;
      rxAddrValid <= evReq & evSel[5];
      rxAddr      <= (evReq && evSel[5]) ? seenAddr : ~rxAddr;
    end
  end
  // Pulled-up clock wire
  assign sclLine = sclDriveLow ? 1'h0 : 1'h1;
endmodule : twcs_engine_model

// ---- verif/twcs_control_status_bench.sv ----
module twcs_control_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'h0;
  logic        rst = 1'h1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, evSel = 8'h00, evPulse;
  logic [31:0] wdata = 32'h0000_0000, rdata, rdat;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
  logic        rready = 1'h0, evReq = 1'h0, masterMode = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, rxAddrValid;
  logic        attnFlag, ifaceEnable, sclDriveLow, sclTick, irq, sclLine;
  logic [1:0]  bresp, rresp, lastResp;
  logic [6:0]  seenAddr = 7'h00, rxAddr;
  int          mismatches = 0, cmpCount = 0;

  always #4 sys_clk = ~sys_clk;

  twcs_control_status i_twcs_control_status (
    .sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .evBusError(evPulse[0]), .evArbLost(evPulse[1]), .evStartSent(evPulse[2]),
    .evAddrSent(evPulse[3]), .evDataSent(evPulse[4]), .evDataRecv(evPulse[6]),
    .evStopRecv(evPulse[7]), .rxAddrValid(rxAddrValid), .rxAddr(rxAddr),
    .masterMode(masterMode), .attnFlag(attnFlag), .ifaceEnable(ifaceEnable),
    .sclDriveLow(sclDriveLow), .sclTick(sclTick), .irq(irq));

  twcs_engine_model i_twcs_engine_model (
    .sys_clk(sys_clk), .rst(rst), .evReq(evReq), .evSel(evSel),
    .seenAddr(seenAddr), .sclDriveLow(sclDriveLow), .evPulse(evPulse),
    .rxAddrValid(rxAddrValid), .rxAddr(rxAddr), .sclLine(sclLine));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (mismatches == 0 && cmpCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    lastResp = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    rdat = rdata;
    lastResp = rresp;
    rready <= 1'h0;
  endtask : rd

  // Event request, then the flag is looked at once the design has seen it
  task automatic fire(input logic [7:0] sel, input logic [6:0] a, input logic expFlag);
    @(posedge sys_clk);
    evReq    <= 1'h1;
    evSel    <= sel;
    seenAddr <= a;
    @(posedge sys_clk);
    evReq <= 1'h0;
    @(posedge sys_clk);
    #1;
    check(attnFlag, expFlag);
  endtask : fire

  task automatic waitTick(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (sclTick !== 1'h1 && n < 1000);
  endtask : waitTick

  initial begin
    int n;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    rd(twcs_pkg::OFF_DIVISOR);
    check(rdat, 32'h0000_0000);
    rd(twcs_pkg::OFF_STATUS);
    check(rdat, 32'h0000_00f8);
    rd(twcs_pkg::OFF_ADDR);
    check(rdat, 32'h0000_00fe);
    rd(8'h18);
    check(lastResp, twcs_pkg::RESP_SLVERR);
    wr(8'h18, 32'h0000_0001);
    check(lastResp, twcs_pkg::RESP_SLVERR);
    wr(twcs_pkg::OFF_DIVISOR, 32'h0000_00a5);
    wr(twcs_pkg::OFF_DIVISOR, 32'h0000_0033, 4'h0);
    rd(twcs_pkg::OFF_DIVISOR);
    check(rdat, 32'h0000_00a5);
    fire(8'h04, 7'h00, 1'h0);
    wr(twcs_pkg::OFF_CONTROL, 32'h0000_0004);
    for (int i = 0; i < 8; i++) begin
      fire(8'h01 << i, 7'h7f, 1'h1);
      rd(twcs_pkg::OFF_STATUS);
      check(rdat, {24'h00_0000, twcs_pkg::EV_CODE[i], 3'h0});
      check(sclLine, 1'h0);
      wr(twcs_pkg::OFF_CONTROL, 32'h0000_0084);
      rd(twcs_pkg::OFF_STATUS);
      check(rdat, 32'h0000_00f8);
      check(sclLine, 1'h1);
    end
    fire(8'h20, 7'h00, 1'h0);
    wr(twcs_pkg::OFF_ADDR, 32'h0000_0021);
    fire(8'h20, 7'h7f, 1'h0);
    fire(8'h20, 7'h00, 1'h1);
    wr(twcs_pkg::OFF_CONTROL, 32'h0000_0084);
    fire(8'h20, 7'h10, 1'h1);
    wr(twcs_pkg::OFF_CONTROL, 32'h0000_0084);
    fire(8'h41, 7'h00, 1'h1);
    rd(twcs_pkg::OFF_STATUS);
    check(rdat, 32'h0000_0000);
    wr(twcs_pkg::OFF_CONTROL, 32'h0000_0084);
    // Disabling the interface drops a pending flag and frees the clock line
    fire(8'h10, 7'h00, 1'h1);
    rd(twcs_pkg::OFF_CONTROL);
    check(rdat, 32'h0000_0084);
    wr(twcs_pkg::OFF_CONTROL, 32'h0000_0000);
    check(attnFlag, 1'h0);
    check(ifaceEnable, 1'h0);
    check(sclLine, 1'h1);
    wr(twcs_pkg::OFF_CONTROL, 32'h0000_0004);
    check(ifaceEnable, 1'h1);
    rd(twcs_pkg::OFF_IRQ_ST);
    check(rdat, 32'h0000_00ff);
    check(irq, 1'h0);
    wr(twcs_pkg::OFF_IRQ_MSK, 32'h0000_0010);
    repeat (3) @(posedge sys_clk);
    check(irq, 1'h1);
    wr(twcs_pkg::OFF_IRQ_ST, 32'h0000_0010);
    repeat (3) @(posedge sys_clk);
    check(irq, 1'h0);
    rd(twcs_pkg::OFF_IRQ_ST);
    check(rdat, 32'h0000_00ef);
    // Divider half periods for every prescale code
    wr(twcs_pkg::OFF_DIVISOR, 32'h0000_0003);
    masterMode <= 1'h1;
    for (int p = 0; p < 4; p++) begin
      wr(twcs_pkg::OFF_STATUS, p);
      rd(twcs_pkg::OFF_STATUS);
      check(rdat, 32'h0000_00f8 | p);
      waitTick(n);
      waitTick(n);
      check(n, 8 + (3 << (2 * p)));
    end
    wr(twcs_pkg::OFF_STATUS, 32'h0000_0000);
    wr(twcs_pkg::OFF_DIVISOR, 32'h0000_0000);
    waitTick(n);
    waitTick(n);
    check(n, 8);
    masterMode <= 1'h0;
    repeat (2) @(posedge sys_clk);
    n = 0;
    repeat (300) begin
      @(posedge sys_clk);
      #1;
      if (sclTick !== 1'h0) n++;
    end
    check(n, 0);
    check(sclDriveLow, 1'h0);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
endmodule : twcs_control_status_bench
